// file: tce_timer.sv
// Capture, encoder and DMA store timer with APB registers
//
// Chosen here: the register offsets and the APB register port.
`timescale 1ns/1ps
module tce_timer
	import tce_pkg::*;
(
	input  wire logic                pclk,
	input  wire logic                presetn,
	input  wire logic                psel,
	input  wire logic                penable,
	input  wire logic                pwrite,
	input  wire logic [7:0]          paddr,
	input  wire logic [31:0]         pwdata,
	output logic      [31:0]         prdata,
	output logic                     pready,
	output logic                     pslverr,
	input  wire logic                capture_input,
	input  wire logic                encoder_input_a,
	input  wire logic                encoder_input_b,
	input  wire logic                sys_wake,
	output logic                     dma_wr_valid,
	output logic      [ADDR_W-1:0]   dma_wr_addr,
	output logic      [31:0]         dma_wr_data,
	output logic                     timer_irq,
	output logic                     encoder_irq,
	output logic                     encoder_wake
);
	tce_enc_if eif ();

	logic [7:0]        timer_mode_control_r;
	logic [2:0]        dma_ctrl_r;
	logic [2:0]        timer_irq_enable_register_r;
	logic [2:0]        timer_flag_register_r;
	logic [2:0]        flag_nxt;
	logic [DATA_W-1:0] timer_data_word_r;
	logic              data_valid_r;
	logic [DATA_W-1:0] timer_end_value_r;
	logic [ADDR_W-1:0] dma_current_address_r;
	logic [ADDR_W-1:0] dma_begin_address_r;
	logic [ADDR_W-1:0] dma_end_address_r;
	logic [3:0]        enc_ctrl_r;
	logic [1:0]        enc_ie_r;
	logic [1:0]        enc_flag_r;
	logic [1:0]        enc_flag_nxt;
	logic [ENC_W-1:0]  encoder_final_value_r;
	logic              cap_prev_r;
	logic              armed_r;
	logic [WIDTH_W-1:0] width_r;
	logic              pready_r;
	logic              pslverr_r;
	logic [31:0]       prdata_r;
	logic              dma_wr_valid_r;
	logic [ADDR_W-1:0] dma_wr_addr_r;
	logic [31:0]       dma_wr_data_r;
	logic              timer_irq_r;
	logic              encoder_irq_r;
	logic              encoder_wake_r;
	logic              acc;
	logic              wr;
	logic              rd;
	logic              mapped;
	logic [31:0]       rdata_nxt;
	logic              active;
	logic              edge_seen;
	logic              sel_edge;
	logic              timeout;
	logic              emit;
	logic [DATA_W-1:0] word_nxt;
	logic              dma_on;
	logic              dma_room;
	logic              dma_hit_end;
	tce_cap_t          cap_mode;

	assign cap_mode = tce_cap_t'(timer_mode_control_r[CTL_EDGE_LO +: 2]);
	assign dma_on   = dma_ctrl_r[DMA_EN_BIT];

	// APB slave: one wait state, so all answers come from flops
	assign acc = psel && penable && pready_r;
	assign wr  = acc && pwrite;
	assign rd  = acc && !pwrite;

	always_comb begin
		mapped    = 1'b1;
		rdata_nxt = '0;
		case (paddr)
			OFF_CTRL:      rdata_nxt[7:0] = timer_mode_control_r;
			OFF_DMA_CTRL:  rdata_nxt[2:0] = dma_ctrl_r;
			OFF_IRQ_EN:    rdata_nxt[2:0] = timer_irq_enable_register_r;
			OFF_FLAGS:     rdata_nxt[2:0] = timer_flag_register_r;
			OFF_DATA:      rdata_nxt[DATA_W-1:0] = timer_data_word_r;
			OFF_END:       rdata_nxt[DATA_W-1:0] = timer_end_value_r;
			OFF_DMA_NOW:   rdata_nxt[ADDR_W-1:0] = dma_current_address_r;
			OFF_DMA_BEG:   rdata_nxt[ADDR_W-1:0] = dma_begin_address_r;
			OFF_DMA_END:   rdata_nxt[ADDR_W-1:0] = dma_end_address_r;
			OFF_ENC_CTRL:  rdata_nxt[5:0] = {eif.dir, 1'b0, enc_ctrl_r};
			OFF_ENC_IE:    rdata_nxt[1:0] = enc_ie_r;
			OFF_ENC_FLAG:  rdata_nxt[1:0] = enc_flag_r;
			OFF_ENC_FINAL: rdata_nxt = encoder_final_value_r;
			OFF_ENC_COUNT: rdata_nxt = eif.count;
			default:       mapped = 1'b0;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_r  <= 1'b0;
			pslverr_r <= 1'b0;
			prdata_r  <= '0;
		end else begin
			pready_r  <= psel && penable && !pready_r;
			pslverr_r <= psel && penable && !pready_r && !mapped;
			prdata_r  <= (psel && penable && !pready_r && !pwrite) ? rdata_nxt : '0;
		end
	end

	// Configuration registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			timer_mode_control_r        <= CTRL_RESET;
			dma_ctrl_r                  <= '0;
			timer_irq_enable_register_r <= '0;
			timer_end_value_r           <= END_RESET;
			dma_begin_address_r         <= '0;
			dma_end_address_r           <= '0;
			enc_ctrl_r                  <= '0;
			enc_ie_r                    <= '0;
			encoder_final_value_r       <= '0;
		end else if (wr) begin
			case (paddr)
				OFF_CTRL:      timer_mode_control_r <= pwdata[7:0];
				OFF_DMA_CTRL:  dma_ctrl_r <= {pwdata[DMA_WRAP_BIT], 1'b0, pwdata[DMA_EN_BIT]};
				OFF_IRQ_EN:    timer_irq_enable_register_r <= pwdata[2:0];
				OFF_END:       timer_end_value_r <= pwdata[DATA_W-1:0];
				OFF_DMA_BEG:   dma_begin_address_r <= {pwdata[ADDR_W-1:2], 2'b00};
				OFF_DMA_END:   dma_end_address_r <= {pwdata[ADDR_W-1:2], 2'b00};
				OFF_ENC_CTRL:  enc_ctrl_r <= pwdata[3:0];
				OFF_ENC_IE:    enc_ie_r <= pwdata[1:0];
				OFF_ENC_FINAL: encoder_final_value_r <= pwdata;
				default:       ;
			endcase
		end
	end

	// Capture engine: input taken every clock, widths in cycles
	assign active    = !timer_mode_control_r[CTL_CLEAR] && timer_mode_control_r[CTL_COUNT_EN]
		&& timer_mode_control_r[CTL_MODE_IN] && cap_mode != TCE_CAP_NONE;
	assign edge_seen = capture_input != cap_prev_r;

	always_comb begin
		case (cap_mode)
			TCE_CAP_ANY:  sel_edge = edge_seen;
			TCE_CAP_FALL: sel_edge = edge_seen && !capture_input;
			TCE_CAP_RISE: sel_edge = edge_seen && capture_input;
			default:      sel_edge = 1'b0;
		endcase
	end

	// Period modes count nothing until their first edge
	assign timeout = active && armed_r && !sel_edge
		&& {1'b0, width_r} >= timer_end_value_r;
	assign emit    = active && armed_r && (sel_edge || timeout);

	always_comb begin
		if (cap_mode == TCE_CAP_ANY) begin
			word_nxt = {cap_prev_r, width_r};
		end else begin
			word_nxt = {timeout, width_r};
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cap_prev_r <= 1'b0;
			armed_r    <= 1'b0;
			width_r    <= '0;
		end else begin
			cap_prev_r <= capture_input;
			if (!active) begin
				armed_r <= 1'b0;
				width_r <= '0;
			end else if (!armed_r) begin
				armed_r <= (cap_mode == TCE_CAP_ANY) || sel_edge;
				width_r <= WIDTH_W'(1);
			end else if (emit) begin
				width_r <= WIDTH_W'(1);
			end else begin
				width_r <= width_r + 1'b1;
			end
		end
	end

	// Data register, emptied by clear-all; a read drops only its valid bit
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			timer_data_word_r <= '0;
			data_valid_r      <= 1'b0;
		end else if (timer_mode_control_r[CTL_CLEAR]) begin
			timer_data_word_r <= '0;
			data_valid_r      <= 1'b0;
		end else if (emit && !dma_on) begin
			timer_data_word_r <= word_nxt;
			data_valid_r      <= 1'b1;
		end else if (rd && paddr == OFF_DATA) begin
			data_valid_r <= 1'b0;
		end
	end

	// DMA store: end address is exclusive, writes stop there unless wrapping
	assign dma_room    = dma_current_address_r != dma_end_address_r;
	assign dma_hit_end = dma_current_address_r + ADDR_W'(4) == dma_end_address_r;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			dma_current_address_r <= '0;
			dma_wr_valid_r        <= 1'b0;
			dma_wr_addr_r         <= '0;
			dma_wr_data_r         <= '0;
		end else begin
			dma_wr_valid_r <= emit && dma_on && dma_room;
			if (!dma_on) begin
				dma_current_address_r <= dma_begin_address_r;
			end else if (emit && dma_room) begin
				dma_wr_addr_r <= dma_current_address_r;
				dma_wr_data_r <= {6'h00, word_nxt};
				if (dma_hit_end && dma_ctrl_r[DMA_WRAP_BIT]) begin
					dma_current_address_r <= dma_begin_address_r;
				end else begin
					dma_current_address_r <= dma_current_address_r + ADDR_W'(4);
				end
			end
		end
	end

	// Flags: hardware set wins over a write-one clear in the same cycle
	always_comb begin
		flag_nxt = timer_flag_register_r;
		if (wr && paddr == OFF_FLAGS) begin
			flag_nxt = flag_nxt & ~pwdata[2:0];
		end
		flag_nxt[FLG_DATA]     = flag_nxt[FLG_DATA] | emit;
		flag_nxt[FLG_TIMEOUT]  = flag_nxt[FLG_TIMEOUT] | timeout;
		flag_nxt[FLG_DMA_DONE] = flag_nxt[FLG_DMA_DONE]
			| (emit && dma_on && dma_room && dma_hit_end);
		if (timer_mode_control_r[CTL_CLEAR]) begin
			flag_nxt = '0;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			timer_flag_register_r <= '0;
			timer_irq_r           <= 1'b0;
		end else begin
			timer_flag_register_r <= flag_nxt;
			timer_irq_r           <= |(flag_nxt & timer_irq_enable_register_r);
		end
	end

	// Encoder side
	assign eif.run         = enc_ctrl_r[ENC_RUN_BIT];
	assign eif.sel         = tce_enc_sel_t'(enc_ctrl_r[ENC_SEL_LO +: 2]);
	assign eif.final_value = encoder_final_value_r;
	assign eif.clr         = rd && paddr == OFF_ENC_COUNT && enc_ctrl_r[ENC_CLR_BIT];

	tce_encoder u_enc (
		.pclk            (pclk),
		.presetn         (presetn),
		.encoder_input_a (encoder_input_a),
		.encoder_input_b (encoder_input_b),
		.eif             (eif)
	);

	always_comb begin
		enc_flag_nxt = enc_flag_r;
		if (wr && paddr == OFF_ENC_FLAG) begin
			enc_flag_nxt = enc_flag_nxt & ~pwdata[1:0];
		end
		enc_flag_nxt[EFL_FWD] = enc_flag_nxt[EFL_FWD] | eif.step_up;
		enc_flag_nxt[EFL_BWD] = enc_flag_nxt[EFL_BWD] | eif.step_dn;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			enc_flag_r     <= '0;
			encoder_irq_r  <= 1'b0;
			encoder_wake_r <= 1'b0;
		end else begin
			enc_flag_r    <= enc_flag_nxt;
			encoder_irq_r <= |(enc_flag_nxt & enc_ie_r);
			if (eif.step_up || eif.step_dn) begin
				encoder_wake_r <= 1'b1;
			end else if (sys_wake && enc_ctrl_r[ENC_CLR_BIT]) begin
				encoder_wake_r <= 1'b0;
			end
		end
	end

	assign prdata       = prdata_r;
	assign pready       = pready_r;
	assign pslverr      = pslverr_r;
	assign dma_wr_valid = dma_wr_valid_r;
	assign dma_wr_addr  = dma_wr_addr_r;
	assign dma_wr_data  = dma_wr_data_r;
	assign timer_irq    = timer_irq_r;
	assign encoder_irq  = encoder_irq_r;
	assign encoder_wake = encoder_wake_r;

	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);

	chk_no_capture_off: assert property (
		(cap_mode == TCE_CAP_NONE) |-> !emit)
		else $error("capture with edge select off");
	chk_anyedge_level_bit: assert property (
		(emit && sel_edge && cap_mode == TCE_CAP_ANY && !dma_on
			&& !timer_mode_control_r[CTL_CLEAR])
		|=> timer_data_word_r[LEVEL_BIT] == !cap_prev_r)
		else $error("level bit not the finished level");
	chk_period_bit_low: assert property (
		(emit && sel_edge && cap_mode != TCE_CAP_ANY && !dma_on)
		|=> !timer_data_word_r[LEVEL_BIT] && data_valid_r)
		else $error("normal period word marked as timeout");
	chk_timeout_flag_set: assert property (
		timeout |=> timer_flag_register_r[FLG_TIMEOUT]
			&& width_r == WIDTH_W'(1))
		else $error("timeout did not flag and restart");
	chk_clear_all_empty: assert property (
		timer_mode_control_r[CTL_CLEAR] |=> !data_valid_r
			&& timer_flag_register_r == '0)
		else $error("clear-all left data or flags");
	chk_data_flag_set: assert property (
		(emit && !timer_mode_control_r[CTL_CLEAR]) |=> timer_flag_register_r[FLG_DATA])
		else $error("capture did not set data flag");
	chk_dma_step_word: assert property (
		(emit && dma_on && dma_room && !dma_hit_end)
		|=> dma_wr_valid_r && dma_current_address_r == $past(dma_current_address_r) + 15'h0004)
		else $error("DMA address did not step one word");
	chk_dma_wrap_load: assert property (
		(emit && dma_on && dma_room && dma_hit_end && dma_ctrl_r[DMA_WRAP_BIT])
		|=> dma_current_address_r == $past(dma_begin_address_r))
		else $error("wrapping DMA did not reload begin");
	chk_width_restart: assert property (
		(emit && active) |=> width_r == WIDTH_W'(1))
		else $error("width count did not restart after a word");
	chk_enc_read_clear: assert property (
		eif.clr |=> eif.count == '0)
		else $error("clear-on-read left a count");
endmodule

// file: tce_pkg.sv
// Constants for the capture, encoder and DMA timer block
package tce_pkg;
	localparam int          DATA_W        = 26;
	localparam int          WIDTH_W       = 25;
	localparam int          LEVEL_BIT     = 25;
	localparam int          ADDR_W        = 15;
	localparam int          ENC_W         = 32;
	localparam logic [25:0] END_RESET     = 26'h3FFFFFF;
	localparam logic [7:0]  OFF_CTRL      = 8'h00;
	localparam logic [7:0]  OFF_DMA_CTRL  = 8'h04;
	localparam logic [7:0]  OFF_IRQ_EN    = 8'h08;
	localparam logic [7:0]  OFF_FLAGS     = 8'h0C;
	localparam logic [7:0]  OFF_DATA      = 8'h10;
	localparam logic [7:0]  OFF_END       = 8'h14;
	localparam logic [7:0]  OFF_DMA_NOW   = 8'h18;
	localparam logic [7:0]  OFF_DMA_BEG   = 8'h1C;
	localparam logic [7:0]  OFF_DMA_END   = 8'h20;
	localparam logic [7:0]  OFF_ENC_CTRL  = 8'h24;
	localparam logic [7:0]  OFF_ENC_IE    = 8'h28;
	localparam logic [7:0]  OFF_ENC_FLAG  = 8'h2C;
	localparam logic [7:0]  OFF_ENC_FINAL = 8'h30;
	localparam logic [7:0]  OFF_ENC_COUNT = 8'h34;
	// Control register fields
	localparam int CTL_CLEAR     = 0;
	localparam int CTL_COUNT_EN  = 1;
	localparam int CTL_MODE_IN   = 2;
	localparam int CTL_EDGE_LO   = 3;
	// DMA control fields
	localparam int DMA_EN_BIT    = 0;
	localparam int DMA_WRAP_BIT  = 2;
	// Flag and enable fields
	localparam int FLG_DATA      = 0;
	localparam int FLG_TIMEOUT   = 1;
	localparam int FLG_DMA_DONE  = 2;
	// Encoder control and flag fields
	localparam int ENC_RUN_BIT   = 0;
	localparam int ENC_SEL_LO    = 1;
	localparam int ENC_CLR_BIT   = 3;
	localparam int ENC_DIR_BIT   = 5;
	localparam int EFL_FWD       = 0;
	localparam int EFL_BWD       = 1;
	localparam logic [7:0] CTRL_RESET = 8'h01;
	typedef enum logic [1:0] {
		TCE_CAP_NONE = 2'h0,
		TCE_CAP_ANY  = 2'h1,
		TCE_CAP_FALL = 2'h2,
		TCE_CAP_RISE = 2'h3
	} tce_cap_t;
	typedef enum logic [1:0] {
		TCE_ENC_IDLE = 2'h0,
		TCE_ENC_B    = 2'h1,
		TCE_ENC_A    = 2'h2,
		TCE_ENC_AB   = 2'h3
	} tce_enc_sel_t;
endpackage

// file: tce_enc_if.sv
// Link between the register side and the quadrature counter
`timescale 1ns/1ps
interface tce_enc_if;
	import tce_pkg::*;
	logic               run;
	tce_enc_sel_t       sel;
	logic               clr;
	logic [ENC_W-1:0]   final_value;
	logic [ENC_W-1:0]   count;
	logic               dir;
	logic               step_up;
	logic               step_dn;
	modport ctl (output run, output sel, output clr, output final_value,
		input count, input dir, input step_up, input step_dn);
	modport enc (input run, input sel, input clr, input final_value,
		output count, output dir, output step_up, output step_dn);
endinterface

// file: tce_encoder.sv
// Quadrature counter with direction tracking
`timescale 1ns/1ps
module tce_encoder
	import tce_pkg::*;
(
	input  wire logic pclk,
	input  wire logic presetn,
	input  wire logic encoder_input_a,
	input  wire logic encoder_input_b,
	tce_enc_if.enc    eif
);
	logic             a_prev_r;
	logic             b_prev_r;
	logic             a_edge;
	logic             b_edge;
	logic             a_down;
	logic             b_up;
	logic             use_a;
	logic             use_b;
	logic             up_nxt;
	logic             dn_nxt;
	logic [ENC_W-1:0] count_r;
	logic             dir_r;
	logic             step_up_r;
	logic             step_dn_r;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			a_prev_r <= 1'b0;
			b_prev_r <= 1'b0;
		end else begin
			a_prev_r <= encoder_input_a;
			b_prev_r <= encoder_input_b;
		end
	end

	always_comb begin
		a_edge = encoder_input_a ^ a_prev_r;
		b_edge = encoder_input_b ^ b_prev_r;
		// A edge counts down when its new level matches B
		a_down = (encoder_input_a == encoder_input_b);
		// B edge counts up when its new level matches A
		b_up   = (encoder_input_b == encoder_input_a);
		use_a  = eif.run && a_edge && (eif.sel == TCE_ENC_A || eif.sel == TCE_ENC_AB);
		use_b  = eif.run && b_edge && (eif.sel == TCE_ENC_B || eif.sel == TCE_ENC_AB);
		// A wins a simultaneous pair of edges; a real encoder never makes one
		up_nxt = use_a ? !a_down : (use_b && b_up);
		dn_nxt = use_a ? a_down : (use_b && !b_up);
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			count_r <= '0;
		end else if (eif.clr) begin
			count_r <= '0;
		end else if (up_nxt) begin
			count_r <= (count_r == eif.final_value) ? '0 : count_r + 1'b1;
		end else if (dn_nxt) begin
			count_r <= (count_r == '0) ? eif.final_value : count_r - 1'b1;
		end
	end

	// Direction follows every input transition, counted or not
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			dir_r <= 1'b0;
		end else if (a_edge) begin
			dir_r <= a_down;
		end else if (b_edge) begin
			dir_r <= !b_up;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			step_up_r <= 1'b0;
			step_dn_r <= 1'b0;
		end else begin
			step_up_r <= up_nxt;
			step_dn_r <= dn_nxt;
		end
	end

	assign eif.count   = count_r;
	assign eif.dir     = dir_r;
	assign eif.step_up = step_up_r;
	assign eif.step_dn = step_dn_r;

	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);

	chk_enc_idle_hold: assert property (
		(eif.sel == TCE_ENC_IDLE && !eif.clr) |=> $stable(count_r))
		else $error("encoder counted while idle");
	chk_enc_a_dir: assert property (
		(eif.run && eif.sel == TCE_ENC_A && a_edge && a_down && !eif.clr
			&& count_r != '0) |=> count_r == $past(count_r) - 1'b1)
		else $error("A edge with matching B did not count down");
	chk_enc_dir_bit: assert property (
		(b_edge && !a_edge) |=> dir_r == !$past(b_up))
		else $error("direction not recomputed on B edge");
endmodule

// file: tce_src.sv
// Pulse source and two-channel rotary encoder model
`timescale 1ns/1ps
module tce_src (
	input  wire logic pclk,
	output logic      capture_input,
	output logic      encoder_input_a,
	output logic      encoder_input_b
);
	initial begin
		capture_input   = 1'b0;
		encoder_input_a = 1'b0;
		encoder_input_b = 1'b0;
	end
	// Changes only after an edge, so each level lasts whole clock cycles
	task automatic level(input logic v, input int w);
		capture_input <= v;
		repeat (w) @(posedge pclk);
	endtask
	// Only one channel moves per step, as a real quadrature wheel does
	task automatic step(input logic on_b);
		if (on_b)
			encoder_input_b <= ~encoder_input_b;
		else
			encoder_input_a <= ~encoder_input_a;
		repeat (4) @(posedge pclk);
	endtask
endmodule

// file: tb.sv
// Self-checking bench for the capture, encoder and DMA timer
`timescale 1ns/1ps
module tb
	import tce_pkg::*;
;
	localparam int                ENDV = 20;
	localparam logic [ADDR_W-1:0] BEG  = 15'h0100;
	localparam logic [ADDR_W-1:0] LIM  = 15'h0120;
	logic              pclk, presetn, psel, penable, pwrite, sys_wake;
	logic [7:0]        paddr;
	logic [31:0]       pwdata, prdata, dd, rv, lf;
	logic              pready, pslverr, cap, ea, eb, dv, tirq, eirq, ewake, err;
	logic [ADDR_W-1:0] da, exp_addr;
	logic [25:0]       q[$];
	logic              cap_on, armed, skip, cprev, e, sel, on_b, up, edir;
	logic [1:0]        eflag;
	int                n_errors, n_compared, cnt, cm, ecnt;
	int                modes[4] = '{0, 1, 3, 2};

	tce_timer dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .capture_input(cap), .encoder_input_a(ea), .encoder_input_b(eb),
		.sys_wake(sys_wake), .dma_wr_valid(dv), .dma_wr_addr(da), .dma_wr_data(dd),
		.timer_irq(tirq), .encoder_irq(eirq), .encoder_wake(ewake));
	tce_src src_u (.pclk(pclk), .capture_input(cap), .encoder_input_a(ea),
		.encoder_input_b(eb));

	initial begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end

	function automatic logic [31:0] lfsr(input logic [31:0] x);
		return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
	endfunction

	task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] g);
		n_compared++;
		if (g !== x) begin
			n_errors++;
			$display("wrong value %s expected %h seen %h", nm, x, g);
		end
	endtask

	// Waits for pready with no assumed latency; a stuck slave counts as an error
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		psel   <= 1'b1;
		pwrite <= w;
		paddr  <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		if (n >= 50)
			n_errors++;
		rv  = prdata;
		err = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask

	task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] mk,
		input logic [31:0] x);
		apb(1'b0, a, 32'h0);
		chk(nm, x, rv & mk);
	endtask

	task automatic give_verdict;
		if (n_errors == 0 && n_compared > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	// Reference capture model: width counted in cycles since the last boundary
	always @(posedge pclk) begin
		if (cap_on) begin
			e   = cap !== cprev;
			sel = e && (cm == 1 || (cm == 3 && cap) || (cm == 2 && !cap));
			if (sel || (armed && cnt >= ENDV)) begin
				if (armed)
					q.push_back({(cm == 1) ? cprev : !sel, cnt[24:0]});
				armed = 1'b1;
				cnt   = 1;
			end else
				cnt++;
			cprev = cap;
		end
	end

	always @(posedge pclk) begin
		if (dv === 1'b1) begin
			chk("dma address", {17'h0, exp_addr}, {17'h0, da});
			if (skip)
				skip = 1'b0;
			else if (q.size() > 0 || cap_on)
				chk("dma word", {6'h0, (q.size() > 0) ? q.pop_front() : 26'h3FFFFFF},
					{6'h0, dd[25:0]});
			exp_addr = (exp_addr + 15'h4 == LIM) ? BEG : exp_addr + 15'h4;
		end
	end

	initial begin
		repeat (40000) @(posedge pclk);
		n_errors++;
		give_verdict();
	end

	initial begin
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		sys_wake = 1'b0;
		cap_on = 1'b0;
		skip = 1'b0;
		exp_addr = BEG;
		lf = 32'h000124CB;
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		rdc("ctrl reset", OFF_CTRL, 32'hFF, {24'h0, CTRL_RESET});
		rdc("end reset", OFF_END, 32'hFFFFFFFF, {6'h0, END_RESET});
		apb(1'b0, 8'h38, 32'h0);
		chk("unmapped error", 32'h1, {31'h0, err});
		apb(1'b1, OFF_END, ENDV);
		apb(1'b1, OFF_DMA_BEG, {17'h0, BEG});
		apb(1'b1, OFF_DMA_END, {17'h0, LIM});
		apb(1'b1, OFF_IRQ_EN, 32'h7);
		for (int m = 0; m < 4; m++) begin
			apb(1'b1, OFF_DMA_CTRL, 32'h5);
			apb(1'b1, OFF_CTRL, {27'h0, modes[m][1:0], 3'h6});
			cm = modes[m];
			skip = (cm == 1);
			exp_addr = BEG;
			armed = 1'b0;
			cnt = 1;
			cprev = cap;
			cap_on = 1'b1;
			for (int i = 0; i < 20; i++) begin
				lf = lfsr(lf);
				src_u.level(!cap, (i == 5) ? 45 : 5 + int'(lf[2:0]));
			end
			// Model stops first; late words are then only address-checked
			cap_on = 1'b0;
			apb(1'b1, OFF_DMA_CTRL, 32'h4);
			repeat (2) @(posedge pclk);
			chk("words pending", 32'h0, 32'(q.size()));
			rdc("flags", OFF_FLAGS, 32'h7, (m != 0) ? 32'h7 : 32'h0);
			chk("timer irq", {31'h0, m != 0}, {31'h0, tirq});
			apb(1'b1, OFF_FLAGS, 32'h4);
			rdc("done cleared", OFF_FLAGS, 32'h4, 32'h0);
			apb(1'b1, OFF_CTRL, 32'h1);
			rdc("flags cleared", OFF_FLAGS, 32'h7, 32'h0);
			chk("timer irq off", 32'h0, {31'h0, tirq});
		end
		// Data register with DMA off in both word kinds, then a ring that must stop at its end
		for (int d = 0; d < 3; d++) begin
			cm = (d == 1) ? 3 : 1;
			apb(1'b1, OFF_DMA_CTRL, {31'h0, d == 2});
			apb(1'b1, OFF_CTRL, {27'h0, cm[1:0], 3'h6});
			skip = (cm == 1);
			exp_addr = BEG;
			armed = 1'b0;
			cnt = 1;
			cprev = cap;
			cap_on = 1'b1;
			// Short levels keep every period below the end value, so no late timeout word
			for (int i = 0; i < 12; i++) begin
				lf = lfsr(lf);
				src_u.level(!cap, 5 + int'(lf[1:0]));
			end
			cap_on = 1'b0;
			apb(1'b1, OFF_CTRL, {27'h0, cm[1:0], 3'h4});
			if (d < 2)
				rdc("data word", OFF_DATA, 32'h3FFFFFF, {6'h0, q[$]});
			q.delete();
		end
		rdc("dma stopped", OFF_DMA_NOW, 32'h7FFF, {17'h0, LIM});
		rdc("done non-looping", OFF_FLAGS, 32'h4, 32'h4);
		apb(1'b1, OFF_IRQ_EN, 32'h3);
		apb(1'b1, OFF_DMA_END, {17'h0, LIM + 15'h0100});
		apb(1'b1, OFF_FLAGS, 32'h7);
		rdc("done cleared non-looping", OFF_FLAGS, 32'h7, 32'h0);
		apb(1'b1, OFF_IRQ_EN, 32'h7);
		chk("timer irq quiet", 32'h0, {31'h0, tirq});
		apb(1'b1, OFF_ENC_FINAL, 32'h64);
		apb(1'b1, OFF_ENC_IE, 32'h3);
		for (int sm = 1; sm < 4; sm++) begin
			apb(1'b1, OFF_ENC_CTRL, {28'h0, 1'b1, sm[1:0], 1'b1});
			apb(1'b0, OFF_ENC_COUNT, 32'h0);
			ecnt = 0;
			eflag = 2'b00;
			for (int i = 0; i < 24; i++) begin
				lf = lfsr(lf);
				on_b = (i == 23) ? (sm != 2) : lf[0];
				up = on_b ? (eb != ea) : (ea == eb);
				if (on_b ? sm[0] : sm[1]) begin
					ecnt = up ? ((ecnt == 100) ? 0 : ecnt + 1) : ((ecnt == 0) ? 100 : ecnt - 1);
					edir = !up;
					eflag = eflag | (up ? 2'b01 : 2'b10);
				end
				src_u.step(on_b);
			end
			rdc("enc count", OFF_ENC_COUNT, 32'hFFFFFFFF, ecnt);
			rdc("enc count cleared", OFF_ENC_COUNT, 32'hFFFFFFFF, 32'h0);
			rdc("enc dir", OFF_ENC_CTRL, 32'h20, {26'h0, edir, 5'h0});
			rdc("enc flags", OFF_ENC_FLAG, 32'h3, {30'h0, eflag});
			chk("enc irq", 32'h1, {31'h0, eirq});
			apb(1'b1, OFF_ENC_FLAG, 32'h3);
			rdc("enc flags cleared", OFF_ENC_FLAG, 32'h3, 32'h0);
			chk("enc wake", 32'h1, {31'h0, ewake});
			sys_wake <= 1'b1;
			@(posedge pclk);
			sys_wake <= 1'b0;
			repeat (2) @(posedge pclk);
			chk("enc wake cleared", 32'h0, {31'h0, ewake});
		end
		give_verdict();
	end
endmodule
